// ===== ssc_pkg.sv
// constants shared by both ends of the status/control register pair
package ssc_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_MASK1 = 4'h6;
  localparam logic [3:0] ADDR_STCTL0 = 4'h7;
  localparam logic [3:0] ADDR_STCTL1 = 4'h8;
  localparam logic [3:0] ADDR_BUSDATA = 4'ha;
  // ----------------------------------------------------------------
  // primary status fields
  // ----------------------------------------------------------------
  localparam int ST0_MEMPAR = 6;
  localparam int ST0_RSTOCC = 7;
  // ----------------------------------------------------------------
  // primary control fields
  // ----------------------------------------------------------------
  localparam int C0_ID_LSB = 0;
  localparam int C0_DIFF = 3;
  localparam int C0_PADIR = 4;
  localparam int C0_TARGET = 5;
  localparam int C0_MEMWR = 6;
  localparam int C0_MEMREQ = 7;
  localparam logic [7:0] C0_RESET = 8'h00;
  // ----------------------------------------------------------------
  // secondary status / control fields
  // ----------------------------------------------------------------
  localparam int ST1_CMDDONE = 3;
  localparam int ST1_ERROR = 4;
  localparam int ST1_RSTIN = 5;
  localparam int C1_SWRST = 0;
  localparam int C1_AUTOPIO = 3;
  localparam int C1_PBOE = 4;
  localparam int C1_MEM16 = 6;
  localparam logic [7:0] C1_RESET = 8'h00;
  // ----------------------------------------------------------------
  // interrupt mask fields
  // ----------------------------------------------------------------
  localparam int M1_CMDDONE = 3;
  localparam int M1_MEMPAR = 4;
  localparam logic [7:0] M1_RESET = 8'h00;
  // ----------------------------------------------------------------
  // general port pins taken over in 16-bit mode
  // ----------------------------------------------------------------
  localparam int PA_HIGH_BYTE_VALID = 2;
  localparam int PA_LOW_BYTE_VALID = 7;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int RST_MIN_NS = 500;
  localparam int RST_MIN_CYC =
    (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RST_MIN_CNT = 8'(RST_MIN_CYC);
endpackage : ssc_pkg

// ===== ssc_if.sv
// register port between the microprocessor end and the controller end
`timescale 1ns/100ps
interface ssc_if;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr_stb;
  logic rd_stb;
  logic irq;
  modport dev (
    input addr,
    input wdata,
    input wr_stb,
    input rd_stb,
    output rdata,
    output irq
  );
  modport host (
    output addr,
    output wdata,
    output wr_stb,
    output rd_stb,
    input rdata,
    input irq
  );
endinterface : ssc_if

// ===== ssc_dev.sv
// controller end: status/control registers and the logic they steer
//
// Contract
// - memory parity error halts, interrupts, sets flags
// - clearing parity mask clears flag, resumes transfer
// - bus reset qualifies only after minimum duration
// - qualified reset latches, interrupts, releases bus signals
// - reset flag cleared only by software/power reset
// - live reset line shown; software polls it
// - secondary error bits readable regardless of mask
// - mode bit: zero single-ended, one differential
// - port direction bit: one output, zero input
// - target bit chooses reselection over selection
// - memory direction bit: one write, zero read
// - zero mask write clears secondary bits 0,1
// - software reads status before clearing mask bits 0/1
// - 16-bit mode: port B high byte, overrides enable
// - 16-bit mode drives byte-valid pins on port A
// - auto PIO bit: one handshake, self-clear, done
// - software moves one data byte per handshake
// - phase mismatch: software clears PIO, restarts
`timescale 1ns/100ps
module ssc_dev
  import ssc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  ssc_if.dev bus,
  input wire logic scsi_rst_pin,
  input wire logic mem_par_err,
  input wire logic dma_active,
  input wire logic mem_cycle_done,
  input wire logic arb_won,
  input wire logic pio_hs_done,
  input wire logic [1:0] st1_event,
  input wire logic [3:0] sec_err,
  input wire logic high_byte_valid,
  input wire logic low_byte_valid,
  input wire logic [7:0] porta_wr_data,
  output logic xfer_halt,
  output logic scsi_release,
  output logic [2:0] own_id,
  output logic diff_mode,
  output logic [7:0] porta_out,
  output logic [7:0] porta_oe,
  output logic portb_oe,
  output logic mem_hi_byte_en,
  output logic mem_cycle_req,
  output logic mem_cycle_write,
  output logic go_select,
  output logic go_reselect,
  output logic pio_req
);
  import ssc_pkg::*;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  logic [7:0] ctl0_q, ctl0_d;
  logic [7:0] ctl1_q, ctl1_d;
  logic [7:0] mask_q;
  logic mempar_q, rstocc_q, cmddone_q;
  logic [1:0] st1_pend_q;
  logic [7:0] rdata_q;
  logic rst_s1_q, rst_s2_q;
  logic [7:0] rst_cnt_q;
  logic go_sel_q, go_resel_q;

  wire wr0 = bus.wr_stb && (bus.addr == ADDR_STCTL0);
  wire wr1 = bus.wr_stb && (bus.addr == ADDR_STCTL1);
  wire wrm = bus.wr_stb && (bus.addr == ADDR_MASK1);
  wire sw_rst = wr1 && bus.wdata[C1_SWRST];

  // ----------------------------------------------------------------
  // bus reset qualification
  // ----------------------------------------------------------------
  // the count only runs on the second synchroniser stage
  wire rst_qual = rst_s2_q && (rst_cnt_q == RST_MIN_CNT - 8'h01);

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
      rst_cnt_q <= 8'h00;
    end
    else
    begin
      rst_s1_q <= scsi_rst_pin;
      rst_s2_q <= rst_s1_q;
      if (!rst_s2_q)
        rst_cnt_q <= 8'h00;
      else if (rst_cnt_q != RST_MIN_CNT)
        rst_cnt_q <= rst_cnt_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // sticky status flags; a set in the clearing cycle wins
  // ----------------------------------------------------------------
  wire mempar_set = mem_par_err && mask_q[M1_MEMPAR];
  wire mempar_clr = wrm && !bus.wdata[M1_MEMPAR];
  wire pend_clr0 = wrm && !bus.wdata[0];
  wire pend_clr1 = wrm && !bus.wdata[1];
  wire cmd_clr = wrm && !bus.wdata[M1_CMDDONE];

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      mempar_q <= 1'b0;
      rstocc_q <= 1'b0;
      cmddone_q <= 1'b0;
      st1_pend_q <= 2'b00;
      mask_q <= M1_RESET;
    end
    else
    begin
      if (mempar_set)
        mempar_q <= 1'b1;
      else if (mempar_clr)
        mempar_q <= 1'b0;
      if (rst_qual)
        rstocc_q <= 1'b1;
      else if (sw_rst)
        rstocc_q <= 1'b0;
      if (pio_hs_done && ctl1_q[C1_AUTOPIO])
        cmddone_q <= 1'b1;
      else if (cmd_clr)
        cmddone_q <= 1'b0;
      if (st1_event[0])
        st1_pend_q[0] <= 1'b1;
      else if (pend_clr0)
        st1_pend_q[0] <= 1'b0;
      if (st1_event[1])
        st1_pend_q[1] <= 1'b1;
      else if (pend_clr1)
        st1_pend_q[1] <= 1'b0;
      if (wrm)
        mask_q <= bus.wdata;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // a request written during DMA stays pending and is granted later
  wire mem_grant = ctl0_q[C0_MEMREQ] && !dma_active && !mempar_q;

  always_comb
  begin
    ctl0_d = ctl0_q;
    if (wr0)
      ctl0_d = bus.wdata;
    if (mem_cycle_done && mem_grant)
      ctl0_d[C0_MEMREQ] = 1'b0;
    ctl1_d = ctl1_q;
    if (wr1)
      ctl1_d = bus.wdata;
    ctl1_d[C1_SWRST] = 1'b0;
    if (pio_hs_done && ctl1_q[C1_AUTOPIO])
      ctl1_d[C1_AUTOPIO] = 1'b0;
    if (sw_rst)
      ctl1_d[C1_AUTOPIO] = 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      ctl0_q <= C0_RESET;
      ctl1_q <= C1_RESET;
    end
    else
    begin
      ctl0_q <= ctl0_d;
      ctl1_q <= ctl1_d;
    end
  end

  // ----------------------------------------------------------------
  // status read-back
  // ----------------------------------------------------------------
  wire err_any = mempar_q || rstocc_q || (|sec_err);
  wire [7:0] st0 = {rstocc_q, mempar_q, sec_err[3:1], 1'b0,
                    sec_err[0], 1'b0};
  wire [7:0] st1 = {2'b00, rst_s2_q, err_any, cmddone_q, 1'b0,
                    st1_pend_q};
  wire [7:0] rd_mux = (bus.addr == ADDR_STCTL0) ? st0 :
                      (bus.addr == ADDR_STCTL1) ? st1 :
                      (bus.addr == ADDR_MASK1) ? mask_q : 8'h00;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      rdata_q <= 8'h00;
    else if (bus.rd_stb)
      rdata_q <= rd_mux;
  end

  // ----------------------------------------------------------------
  // arbitration outcome
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      go_sel_q <= 1'b0;
      go_resel_q <= 1'b0;
    end
    else
    begin
      go_sel_q <= arb_won && !ctl0_q[C0_TARGET];
      go_resel_q <= arb_won && ctl0_q[C0_TARGET];
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  wire m16 = ctl1_q[C1_MEM16];
  wire [7:0] pa_dir = ctl0_q[C0_PADIR] ? 8'hff : 8'h00;
  wire [7:0] pa_m16 = m16 ? 8'h84 : 8'h00;

  assign bus.rdata = rdata_q;
  assign bus.irq = mempar_q || rstocc_q ||
                   (cmddone_q && mask_q[M1_CMDDONE]) ||
                   (|(st1_pend_q & mask_q[1:0]));
  assign xfer_halt = mempar_q;
  assign scsi_release = rstocc_q;
  assign own_id = ctl0_q[C0_ID_LSB +: 3];
  assign diff_mode = ctl0_q[C0_DIFF];
  assign porta_oe = pa_dir | pa_m16;
  always_comb
  begin
    porta_out = porta_wr_data;
    if (m16)
    begin
      porta_out[PA_HIGH_BYTE_VALID] = high_byte_valid;
      porta_out[PA_LOW_BYTE_VALID] = low_byte_valid;
    end
  end
  assign portb_oe = ctl1_q[C1_PBOE] && !m16;
  assign mem_hi_byte_en = m16;
  assign mem_cycle_req = mem_grant;
  assign mem_cycle_write = ctl0_q[C0_MEMWR];
  assign go_select = go_sel_q;
  assign go_reselect = go_resel_q;
  assign pio_req = ctl1_q[C1_AUTOPIO] && !rstocc_q;
endmodule : ssc_dev

// ===== ssc_host.sv
// microprocessor end: turns user commands into register strobes
`timescale 1ns/100ps
module ssc_host
  import ssc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  ssc_if.host bus,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [3:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic phase_mismatch,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic [7:0] saved_st1,
  output logic scsi_rst_live,
  output logic irq
);
  import ssc_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_PRE, S_PCAP, S_ACC, S_CAP}
    ssc_hst_type;
  ssc_hst_type st_q, st_d;
  logic op_wr_q;
  logic [3:0] op_addr_q;
  logic [7:0] op_data_q;
  logic [7:0] ctl1_shadow_q;
  logic abort_q;
  logic rsp_valid_q;
  logic [7:0] rsp_data_q, saved_q;
  logic rst_live_q;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  // masking bits 0/1 discards pending status, so read it first
  wire need_pre = cmd_write && (cmd_addr == ADDR_MASK1) &&
                  (cmd_wdata[1:0] != 2'b11);
  wire do_abort = abort_q && ctl1_shadow_q[C1_AUTOPIO];
  wire take = (st_q == S_IDLE) && !do_abort && cmd_valid;
  wire [7:0] abort_val = ctl1_shadow_q & ~(8'h01 << C1_AUTOPIO);

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      S_IDLE:
        if (do_abort)
          st_d = S_ACC;
        else if (cmd_valid)
          st_d = need_pre ? S_PRE : S_ACC;
      S_PRE:
        st_d = S_PCAP;
      S_PCAP:
        st_d = S_ACC;
      S_ACC:
        st_d = op_wr_q ? S_IDLE : S_CAP;
      S_CAP:
        st_d = S_IDLE;
      default:
        st_d = S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      st_q <= S_IDLE;
      op_wr_q <= 1'b0;
      op_addr_q <= 4'h0;
      op_data_q <= 8'h00;
      abort_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      if (phase_mismatch)
        abort_q <= 1'b1;
      else if (st_q == S_IDLE && do_abort)
        abort_q <= 1'b0;
      else if (!ctl1_shadow_q[C1_AUTOPIO])
        abort_q <= 1'b0;
      if (st_q == S_IDLE && do_abort)
      begin
        op_wr_q <= 1'b1;
        op_addr_q <= ADDR_STCTL1;
        op_data_q <= abort_val;
      end
      else if (take)
      begin
        op_wr_q <= cmd_write;
        op_addr_q <= cmd_addr;
        op_data_q <= cmd_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // responses and shadows
  // ----------------------------------------------------------------
  // control 1 cannot be read back, so its last written value is kept
  wire wr_ctl1 = (st_q == S_ACC) && op_wr_q && (op_addr_q == ADDR_STCTL1);
  wire st1_seen = (st_q == S_PCAP) ||
                  ((st_q == S_CAP) && (op_addr_q == ADDR_STCTL1));

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      ctl1_shadow_q <= C1_RESET;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 8'h00;
      saved_q <= 8'h00;
      rst_live_q <= 1'b0;
    end
    else
    begin
      rsp_valid_q <= (st_q == S_CAP);
      if (wr_ctl1)
        ctl1_shadow_q <= op_data_q;
      if (st_q == S_CAP)
        rsp_data_q <= bus.rdata;
      if (st_q == S_PCAP)
        saved_q <= bus.rdata;
      if (st1_seen)
        rst_live_q <= bus.rdata[ST1_RSTIN];
    end
  end

  assign bus.addr = (st_q == S_PRE) ? ADDR_STCTL1 : op_addr_q;
  assign bus.wdata = op_data_q;
  assign bus.wr_stb = (st_q == S_ACC) && op_wr_q;
  assign bus.rd_stb = (st_q == S_PRE) || ((st_q == S_ACC) && !op_wr_q);
  assign cmd_ready = (st_q == S_IDLE) && !do_abort;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign saved_st1 = saved_q;
  assign scsi_rst_live = rst_live_q;
  assign irq = bus.irq;
endmodule : ssc_host

// ===== ssc_sva.sv
// concurrent checks on the register port between the two ends
`timescale 1ns/100ps
module ssc_sva
  import ssc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic irq
);
  // ------------------------------------------------------------------
  // register port checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  a_strobe_excl: assert property (
    !(wr_stb && rd_stb)) else $error("read and write strobe together");
  a_wr_single: assert property (
    wr_stb |=> !wr_stb) else $error("write strobe longer than one cycle");
  a_rd_single: assert property (
    rd_stb |=> !rd_stb) else $error("read strobe longer than one cycle");
  a_rdata_hold: assert property (
    !rd_stb |=> $stable(rdata)) else $error("read data moved without read");
  a_unmapped_zero: assert property (
    rd_stb && (addr < ADDR_MASK1 || addr > ADDR_STCTL1) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  // a mask write clearing bit 0 or 1 must be preceded by a status read
  a_mask_pre_read: assert property (
    wr_stb && addr == ADDR_MASK1 && wdata[1:0] != 2'h3
    |-> $past(rd_stb, 2) && $past(addr, 2) == ADDR_STCTL1)
    else $error("mask cleared without status read");
  a_flag_irq: assert property (
    (rd_stb && addr == ADDR_STCTL0) ##1
    (rdata[ST0_MEMPAR] || rdata[ST0_RSTOCC]) |-> irq)
    else $error("error flag without interrupt");
  a_err_summary: assert property (
    (rd_stb && addr == ADDR_STCTL0) ##1
    (rdata[ST0_MEMPAR] || rdata[ST0_RSTOCC]) ##2
    (rd_stb && addr == ADDR_STCTL1) |=> rdata[ST1_ERROR])
    else $error("summary error bit missing");
  a_irq_reset: assert property (
    $rose(rstn) |-> !irq) else $error("interrupt set after reset");
endmodule : ssc_sva

// ===== scsi_status_control_regs_tb.sv
// self-checking bench: host end and controller end joined back to back
`timescale 1ns/100ps
module scsi_status_control_regs_tb;
  import ssc_pkg::*;
  logic sys_clk, rstn, scsi_rst_pin, mem_par_err, dma_active;
  logic mem_cycle_done, arb_won, pio_hs_done, high_byte_valid;
  logic low_byte_valid, cmd_valid, cmd_write, phase_mismatch;
  logic [1:0] st1_event;
  logic [3:0] sec_err, cmd_addr;
  logic [7:0] porta_wr_data, cmd_wdata, porta_out, porta_oe;
  logic [7:0] rsp_data, saved_st1;
  logic xfer_halt, scsi_release, diff_mode, portb_oe, mem_hi_byte_en;
  logic mem_cycle_req, mem_cycle_write, go_select, go_reselect, pio_req;
  logic cmd_ready, rsp_valid, scsi_rst_live, irq;
  logic [2:0] own_id;
  int failures, cmp_count;
  ssc_if bus();
  ssc_dev i_ssc_dev(.sys_clk, .rstn, .bus(bus), .scsi_rst_pin,
    .mem_par_err, .dma_active, .mem_cycle_done, .arb_won, .pio_hs_done,
    .st1_event, .sec_err, .high_byte_valid, .low_byte_valid,
    .porta_wr_data, .xfer_halt, .scsi_release, .own_id, .diff_mode,
    .porta_out, .porta_oe, .portb_oe, .mem_hi_byte_en, .mem_cycle_req,
    .mem_cycle_write, .go_select, .go_reselect, .pio_req);
  ssc_host i_ssc_host(.sys_clk, .rstn, .bus(bus), .cmd_valid, .cmd_write,
    .cmd_addr, .cmd_wdata, .phase_mismatch, .cmd_ready, .rsp_valid,
    .rsp_data, .saved_st1, .scsi_rst_live, .irq);
  ssc_sva i_ssc_sva(.sys_clk, .rstn, .addr(bus.addr), .wdata(bus.wdata),
    .rdata(bus.rdata), .wr_stb(bus.wr_stb), .rd_stb(bus.rd_stb),
    .irq(bus.irq));
  // ------------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // inputs always move 1 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic req(input logic w, input logic [3:0] a,
    input logic [7:0] d);
    int n;
    n = 0;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    while (cmd_ready !== 1'b1 && n < 40)
    begin
      cyc(1);
      n++;
    end
    chk({7'h00, cmd_ready}, 8'h01);
    cyc(1);
    cmd_valid = 1'b0;
  endtask : req
  // four cycles covers the status read before a clearing mask write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    req(1'b1, a, d);
    cyc(4);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    int n;
    n = 0;
    req(1'b0, a, 8'h00);
    while (rsp_valid !== 1'b1 && n < 10)
    begin
      cyc(1);
      n++;
    end
    chk({7'h00, rsp_valid}, 8'h01);
    chk(rsp_data, exp);
  endtask : rd
  task automatic tally_and_finish;
    if (failures == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // ------------------------------------------------------------------
  // clock, watchdog and tests
  // ------------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    tally_and_finish();
  end
  initial
  begin
    {rstn, scsi_rst_pin, mem_par_err, dma_active, mem_cycle_done} = '0;
    {arb_won, pio_hs_done, high_byte_valid, low_byte_valid} = '0;
    {cmd_valid, cmd_write, phase_mismatch, st1_event, sec_err} = '0;
    {cmd_addr, cmd_wdata} = '0;
    porta_wr_data = 8'h81;
    cyc(20);
    rstn = 1'b1;
    chk(porta_oe, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      wr(ADDR_STCTL0, 8'(i));
      chk({3'h0, diff_mode, mem_cycle_write, own_id}, 8'(i));
    end
    wr(ADDR_STCTL0, 8'h5f);
    chk({3'h0, diff_mode, mem_cycle_write, own_id}, 8'h1f);
    chk(porta_oe, 8'hff);
    sec_err = 4'hf;
    rd(ADDR_STCTL0, 8'h3a);
    for (int t = 0; t < 2; t++)
    begin
      wr(ADDR_STCTL0, 8'(t * 32));
      arb_won = 1'b1;
      cyc(1);
      arb_won = 1'b0;
      chk({6'h00, go_select, go_reselect}, 8'(2 - t));
    end
    dma_active = 1'b1;
    wr(ADDR_STCTL0, 8'h80);
    chk({7'h00, mem_cycle_req}, 8'h00);
    dma_active = 1'b0;
    cyc(1);
    chk({7'h00, mem_cycle_req}, 8'h01);
    mem_cycle_done = 1'b1;
    cyc(1);
    mem_cycle_done = 1'b0;
    cyc(1);
    chk({7'h00, mem_cycle_req}, 8'h00);
    sec_err = 4'h0;
    wr(ADDR_MASK1, 8'h10);
    mem_par_err = 1'b1;
    cyc(1);
    mem_par_err = 1'b0;
    cyc(1);
    chk({6'h00, xfer_halt, irq}, 8'h03);
    rd(ADDR_STCTL0, 8'h40);
    rd(ADDR_STCTL1, 8'h10);
    wr(ADDR_MASK1, 8'h00);
    chk({6'h00, xfer_halt, irq}, 8'h00);
    wr(ADDR_MASK1, 8'h03);
    st1_event = 2'h3;
    cyc(1);
    st1_event = 2'h0;
    rd(ADDR_STCTL1, 8'h03);
    wr(ADDR_MASK1, 8'h00);
    chk(saved_st1, 8'h03);
    rd(ADDR_STCTL1, 8'h00);
    wr(ADDR_STCTL0, 8'h00);
    wr(ADDR_STCTL1, 8'h10);
    chk({6'h00, portb_oe, mem_hi_byte_en}, 8'h02);
    high_byte_valid = 1'b1;
    wr(ADDR_STCTL1, 8'h50);
    chk({6'h00, portb_oe, mem_hi_byte_en}, 8'h01);
    chk(porta_oe, 8'h84);
    chk(porta_out, 8'h05);
    wr(ADDR_MASK1, 8'h08);
    wr(ADDR_STCTL1, 8'h08);
    chk({7'h00, pio_req}, 8'h01);
    // the data register is outside this block and reads as zero here
    wr(ADDR_BUSDATA, 8'h5a);
    rd(ADDR_BUSDATA, 8'h00);
    chk({7'h00, pio_req}, 8'h01);
    pio_hs_done = 1'b1;
    cyc(1);
    pio_hs_done = 1'b0;
    cyc(1);
    chk({6'h00, pio_req, irq}, 8'h01);
    rd(ADDR_STCTL1, 8'h08);
    wr(ADDR_MASK1, 8'h00);
    wr(ADDR_STCTL1, 8'h08);
    phase_mismatch = 1'b1;
    cyc(1);
    phase_mismatch = 1'b0;
    cyc(8);
    chk({7'h00, pio_req}, 8'h00);
    // a short pulse must not leave a partial count behind
    scsi_rst_pin = 1'b1;
    cyc(50);
    scsi_rst_pin = 1'b0;
    cyc(5);
    scsi_rst_pin = 1'b1;
    cyc(95);
    chk({6'h00, scsi_release, irq}, 8'h00);
    cyc(15);
    chk({6'h00, scsi_release, irq}, 8'h03);
    rd(ADDR_STCTL1, 8'h30);
    chk({7'h00, scsi_rst_live}, 8'h01);
    scsi_rst_pin = 1'b0;
    cyc(4);
    rd(ADDR_STCTL1, 8'h10);
    rd(ADDR_STCTL0, 8'h80);
    wr(ADDR_STCTL1, 8'h01);
    chk({6'h00, scsi_release, irq}, 8'h00);
    rd(ADDR_STCTL0, 8'h00);
    tally_and_finish();
  end
endmodule : scsi_status_control_regs_tb
